// file: core/pld_map.vh
`ifndef PLD_MAP_VH
`define PLD_MAP_VH

// ****************************************************************
// Field widths
// ****************************************************************
`define PLD_REF_MOD_W        12
`define PLD_FB_MOD_W         15
`define PLD_STAGE_CODE_W     2
`define PLD_STAGE_MOD_W      3
`define PLD_RATIO_SEL_W      3
`define PLD_PUMP_W           2
`define PLD_LINE_CNT_W       16

// ****************************************************************
// Reset values of the configuration storage
// ****************************************************************
`define PLD_RST_REF_MOD      12'h001
`define PLD_RST_FB_MOD       15'h0001
`define PLD_RST_STAGE_CODE   2'h0
`define PLD_RST_RATIO_SEL    3'h0
`define PLD_RST_PUMP         2'h0

// ****************************************************************
// Stage code to stage modulus
// ****************************************************************
`define PLD_STAGE_CODE0_MOD  3'h1
`define PLD_STAGE_CODE1_MOD  3'h2
`define PLD_STAGE_CODE2_MOD  3'h3
`define PLD_STAGE_CODE3_MOD  3'h4

// ****************************************************************
// Special codes
// ****************************************************************
`define PLD_RATIO_OSC_OFF    3'h7
`define PLD_PUMP_32UA        2'h3
`define PLD_PD_DIV_DIV       2'h0
`define PLD_PD_EXT_DIV       2'h1
`define PLD_PD_PIN_DIV       2'h2
`define PLD_PD_PIN_PIN       2'h3

`endif

// file: core/pld_mod_counter.v
`include "pld_map.vh"

// ****************************************************************
// Modulus counter: one output pulse per full count of input ticks.
// A modulus field of zero stands for two to the power of W.
// ****************************************************************
module pld_mod_counter #(
    parameter W = 12
) (
    input  wire         sys_clk,   // System clock
    input  wire         rst,       // Synchronous reset, active high
    input  wire [W-1:0] modulus,   // Programmed modulus, zero means 2**W
    input  wire         tickIn,    // Input event, one cycle
    output reg          pulseOut   // One pulse per full count, registered
);

    reg  [W-1:0] count_q;
    wire [W-1:0] lastCount;
    wire         atLast;

    assign lastCount = modulus - {{(W-1){1'b0}}, 1'b1};
    // A count already past a lowered modulus also reloads.
    assign atLast    = (count_q >= lastCount);

    always @(posedge sys_clk) begin
        if (rst) begin
            count_q  <= {W{1'b0}};
            pulseOut <= 1'b0;
        end else begin
            pulseOut <= tickIn & atLast;
            if (tickIn) begin
                if (atLast) begin
                    count_q <= {W{1'b0}};
                end else begin
                    count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

// file: core/pld_divider_path.v
`include "pld_map.vh"

module pld_divider_path #(
    parameter REF_W  = `PLD_REF_MOD_W,
    parameter FB_W   = `PLD_FB_MOD_W,
    parameter LINE_W = `PLD_LINE_CNT_W
) (
    input  wire                          sys_clk,                    // System clock, 20 MHz
    input  wire                          rst,                        // Synchronous reset, active high
    input  wire                          cfgLoad,                    // Host write strobe for all settings
    input  wire                          refdivSourceSelect,         // 0 crystal, 1 reference pin
    input  wire                          detectorPrimarySelect,      // Detector reference select
    input  wire                          detectorSecondarySelect,    // Detector feedback select
    input  wire [REF_W-1:0]              inputDivideModulus,         // Input divider modulus, 0 is 4096
    input  wire                          loopDividerSourceSelect,    // 1 oscillator, 0 post divider
    input  wire [FB_W-1:0]               loopDivideModulus,          // Loop divider modulus, 0 is 32768
    input  wire [`PLD_STAGE_CODE_W-1:0]  outputStageOneModulus,      // Post stage one code
    input  wire [`PLD_STAGE_CODE_W-1:0]  outputStageTwoModulus,      // Post stage two code
    input  wire [`PLD_STAGE_CODE_W-1:0]  outputStageThreeModulus,    // Post stage three code
    input  wire                          filterPathSelect,           // 0 internal, 1 external filter
    input  wire                          crystalFineTuneEnable,      // 1 enables fine tune
    input  wire                          crystalDetectorDisable,     // 1 disables crystal detector
    input  wire                          oscillatorRangeSelect,      // 0 high, 1 low speed range
    input  wire [`PLD_RATIO_SEL_W-1:0]   crystalRatioTableSelect,    // 7 turns crystal off
    input  wire [`PLD_PUMP_W-1:0]        pumpCurrentRange,           // Charge pump range code
    input  wire                          oscillatorKindBit,          // Oscillator kind flag
    input  wire                          crystalTick,                // Crystal oscillator edge event
    input  wire                          refPinTick,                 // Reference pin edge event
    input  wire                          externalLoopInputPin,       // External feedback edge event
    input  wire                          vcoTick,                    // Main oscillator edge event
    output reg                           detectorRefTick,            // Detector reference input
    output reg                           detectorFbTick,             // Detector feedback input
    output wire                          outClkTick,                 // Post divider output pulse
    output reg                           externalFilterOn,           // External filter path chosen
    output reg                           fineTuneOn,                 // Crystal fine tune active
    output reg                           crystalDetectorOn,          // Crystal loop detector active
    output reg                           lowSpeedRange,              // Low speed oscillator range
    output reg                           crystalOscOff,              // Crystal oscillator stopped
    output reg  [`PLD_PUMP_W-1:0]        pumpRangeOut,               // Applied pump range code
    output reg                           pump32uA,                   // 32 uA pump range selected
    output reg                           oscillatorKindOut,          // Applied oscillator kind
    output reg  [LINE_W-1:0]             clocksPerLine,              // Output clocks in last line
    output reg                           lineCountMatch              // Last line count equals modulus
);

    // ****************************************************************
    // Configuration storage
    // ****************************************************************
    reg                          refSrc_q;
    reg                          pdPrimary_q;
    reg                          pdSecondary_q;
    reg  [REF_W-1:0]             refMod_q;
    reg                          fbSrc_q;
    reg  [FB_W-1:0]              fbMod_q;
    reg  [3*`PLD_STAGE_CODE_W-1:0] stageCodes_q;
    reg                          filter_q;
    reg                          tune_q;
    reg                          xdetDis_q;
    reg                          range_q;
    reg  [`PLD_RATIO_SEL_W-1:0]  ratio_q;
    reg  [`PLD_PUMP_W-1:0]       pump_q;
    reg                          kind_q;

    always @(posedge sys_clk) begin
        if (rst) begin
            refSrc_q      <= 1'b0;
            pdPrimary_q   <= 1'b0;
            pdSecondary_q <= 1'b0;
            refMod_q      <= `PLD_RST_REF_MOD;
            fbSrc_q       <= 1'b0;
            fbMod_q       <= `PLD_RST_FB_MOD;
            stageCodes_q  <= {3{`PLD_RST_STAGE_CODE}};
            filter_q      <= 1'b0;
            tune_q        <= 1'b0;
            xdetDis_q     <= 1'b0;
            range_q       <= 1'b0;
            ratio_q       <= `PLD_RST_RATIO_SEL;
            pump_q        <= `PLD_RST_PUMP;
            kind_q        <= 1'b0;
        end else if (cfgLoad) begin
            refSrc_q      <= refdivSourceSelect;
            pdPrimary_q   <= detectorPrimarySelect;
            pdSecondary_q <= detectorSecondarySelect;
            refMod_q      <= inputDivideModulus;
            fbSrc_q       <= loopDividerSourceSelect;
            fbMod_q       <= loopDivideModulus;
            stageCodes_q  <= {outputStageThreeModulus, outputStageTwoModulus, outputStageOneModulus};
            filter_q      <= filterPathSelect;
            tune_q        <= crystalFineTuneEnable;
            xdetDis_q     <= crystalDetectorDisable;
            range_q       <= oscillatorRangeSelect;
            ratio_q       <= crystalRatioTableSelect;
            pump_q        <= pumpCurrentRange;
            kind_q        <= oscillatorKindBit;
        end
    end

    // ****************************************************************
    // Mode outputs
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (rst) begin
            externalFilterOn  <= 1'b0;
            fineTuneOn        <= 1'b0;
            crystalDetectorOn <= 1'b0;
            lowSpeedRange     <= 1'b0;
            crystalOscOff     <= 1'b0;
            pumpRangeOut      <= `PLD_RST_PUMP;
            pump32uA          <= 1'b0;
            oscillatorKindOut <= 1'b0;
        end else begin
            externalFilterOn  <= filter_q;
            fineTuneOn        <= tune_q;
            crystalDetectorOn <= ~xdetDis_q;
            lowSpeedRange     <= range_q;
            crystalOscOff     <= (ratio_q == `PLD_RATIO_OSC_OFF);
            pumpRangeOut      <= pump_q;
            pump32uA          <= (pump_q == `PLD_PUMP_32UA);
            oscillatorKindOut <= kind_q;
        end
    end

    // ****************************************************************
    // Input divider with source select
    // ****************************************************************
    wire crystalLive;
    wire refSrcTick;
    wire refDivPulse;

    // A stopped crystal delivers no edges.
    assign crystalLive = crystalTick & (ratio_q != `PLD_RATIO_OSC_OFF);
    assign refSrcTick  = refSrc_q ? refPinTick : crystalLive;

    pld_mod_counter #(
        .W(REF_W)
    ) uRefDiv (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .modulus  (refMod_q),
        .tickIn   (refSrcTick),
        .pulseOut (refDivPulse)
    );

    // ****************************************************************
    // Post divider, three cascaded stages
    // ****************************************************************
    function [`PLD_STAGE_MOD_W-1:0] stageMod;
        input [`PLD_STAGE_CODE_W-1:0] code;
        begin
            case (code)
                2'h0:    stageMod = `PLD_STAGE_CODE0_MOD;
                2'h1:    stageMod = `PLD_STAGE_CODE1_MOD;
                2'h2:    stageMod = `PLD_STAGE_CODE2_MOD;
                default: stageMod = `PLD_STAGE_CODE3_MOD;
            endcase
        end
    endfunction

    wire [3:0] stageChain;

    assign stageChain[0] = vcoTick;

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : gStage
            pld_mod_counter #(
                .W(`PLD_STAGE_MOD_W)
            ) uStage (
                .sys_clk  (sys_clk),
                .rst      (rst),
                .modulus  (stageMod(stageCodes_q[2*i+1:2*i])),
                .tickIn   (stageChain[i]),
                .pulseOut (stageChain[i+1])
            );
        end
    endgenerate

    assign outClkTick = stageChain[3];

    // ****************************************************************
    // Loop divider with source select
    // ****************************************************************
    wire fbSrcTick;
    wire fbDivPulse;

    assign fbSrcTick = fbSrc_q ? vcoTick : outClkTick;

    pld_mod_counter #(
        .W(FB_W)
    ) uFbDiv (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .modulus  (fbMod_q),
        .tickIn   (fbSrcTick),
        .pulseOut (fbDivPulse)
    );

    // ****************************************************************
    // Phase detector input selection
    // ****************************************************************
    wire [1:0] pdSel;

    assign pdSel = {pdPrimary_q, pdSecondary_q};

    always @(posedge sys_clk) begin
        if (rst) begin
            detectorRefTick <= 1'b0;
            detectorFbTick  <= 1'b0;
        end else begin
            case (pdSel)
                `PLD_PD_DIV_DIV: begin
                    detectorRefTick <= refDivPulse;
                    detectorFbTick  <= fbDivPulse;
                end
                `PLD_PD_PIN_DIV: begin
                    detectorRefTick <= refPinTick;
                    detectorFbTick  <= fbDivPulse;
                end
                `PLD_PD_PIN_PIN: begin
                    detectorRefTick <= refPinTick;
                    detectorFbTick  <= externalLoopInputPin;
                end
                default: begin
                    detectorRefTick <= refDivPulse;
                    detectorFbTick  <= externalLoopInputPin;
                end
            endcase
        end
    end

    // ****************************************************************
    // Line monitor: output clocks between detector reference events
    // ****************************************************************
    reg  [LINE_W-1:0] lineCnt_q;
    wire [LINE_W-1:0] lineCntInc;
    wire [LINE_W-1:0] lineCntStart;
    wire [LINE_W-1:0] fbModWide;

    assign lineCntInc   = lineCnt_q + {{(LINE_W-1){1'b0}}, 1'b1};
    assign lineCntStart = outClkTick ? {{(LINE_W-1){1'b0}}, 1'b1} : {LINE_W{1'b0}};
    assign fbModWide    = {{(LINE_W-FB_W){1'b0}}, fbMod_q};

    always @(posedge sys_clk) begin
        if (rst) begin
            lineCnt_q      <= {LINE_W{1'b0}};
            clocksPerLine  <= {LINE_W{1'b0}};
            lineCountMatch <= 1'b0;
        end else if (detectorRefTick) begin
            clocksPerLine  <= lineCnt_q;
            lineCountMatch <= (lineCnt_q == fbModWide);
            lineCnt_q      <= lineCntStart;
        end else if (outClkTick) begin
            lineCnt_q <= lineCntInc;
        end
    end

endmodule

// file: bench/pld_divider_path_sva.sv
module pld_divider_path_sva #(
    parameter FB_W   = 15,
    parameter LINE_W = 16
) (
    input wire              sys_clk,                  // Clock
    input wire              rst,                      // Reset
    input wire              cfgLoad,                  // Write strobe
    input wire              detectorPrimarySelect,    // Detector select
    input wire              detectorSecondarySelect,  // Detector select
    input wire [FB_W-1:0]   loopDivideModulus,        // Loop modulus
    input wire              filterPathSelect,         // Filter select
    input wire              crystalFineTuneEnable,    // Tune enable
    input wire              crystalDetectorDisable,   // Detector disable
    input wire              oscillatorRangeSelect,    // Range select
    input wire [2:0]        crystalRatioTableSelect,  // Ratio code
    input wire [1:0]        pumpCurrentRange,         // Pump code
    input wire              refPinTick,               // Pin event
    input wire              externalLoopInputPin,     // Loop pin event
    input wire              detectorRefTick,          // Detector input
    input wire              detectorFbTick,           // Detector input
    input wire              externalFilterOn,         // Mode out
    input wire              fineTuneOn,               // Mode out
    input wire              crystalDetectorOn,        // Mode out
    input wire              lowSpeedRange,            // Mode out
    input wire              crystalOscOff,            // Mode out
    input wire [1:0]        pumpRangeOut,             // Mode out
    input wire              pump32uA,                 // Mode out
    input wire [LINE_W-1:0] clocksPerLine,            // Line count
    input wire              lineCountMatch            // Line match
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Mirror of the stored selects and loop modulus.
    // ****************************************************************
    logic            primSel_q;
    logic            secSel_q;
    logic [FB_W-1:0] fbMod_q;
    always @(posedge sys_clk) begin
        if (rst) begin
            primSel_q <= 1'b0;
            secSel_q  <= 1'b0;
            fbMod_q   <= {{(FB_W-1){1'b0}}, 1'b1};
        end else if (cfgLoad) begin
            primSel_q <= detectorPrimarySelect;
            secSel_q  <= detectorSecondarySelect;
            fbMod_q   <= loopDivideModulus;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_filter_follows: assert property (
        cfgLoad |-> ##2 externalFilterOn == $past(filterPathSelect, 2)) else $error("filter mode wrong");
    a_tune_follows: assert property (
        cfgLoad |-> ##2 (fineTuneOn == $past(crystalFineTuneEnable, 2)
                         && crystalDetectorOn == !$past(crystalDetectorDisable, 2))) else $error("tune mode wrong");
    a_range_follows: assert property (
        cfgLoad |-> ##2 lowSpeedRange == $past(oscillatorRangeSelect, 2)) else $error("range mode wrong");
    a_osc_off_code: assert property (
        cfgLoad |-> ##2 crystalOscOff == ($past(crystalRatioTableSelect, 2) == 3'h7)) else $error("osc off wrong");
    a_pump_range_code: assert property (
        cfgLoad |-> ##2 (pumpRangeOut == $past(pumpCurrentRange, 2)
                         && pump32uA == ($past(pumpCurrentRange, 2) == 2'h3))) else $error("pump range wrong");
    a_modes_hold: assert property (
        !$past(cfgLoad, 2) |-> $stable(pumpRangeOut) && $stable(externalFilterOn)) else $error("mode changed");
    a_pin_direct: assert property (
        primSel_q |=> detectorRefTick == $past(refPinTick)) else $error("pin path wrong");
    a_loop_pin_direct: assert property (
        secSel_q |=> detectorFbTick == $past(externalLoopInputPin)) else $error("loop pin path wrong");
    a_line_match: assert property (
        detectorRefTick |=> lineCountMatch == (clocksPerLine == LINE_W'($past(fbMod_q)))) else $error("match wrong");
endmodule

bind pld_divider_path pld_divider_path_sva #(.FB_W(FB_W), .LINE_W(LINE_W)) sva_u (
    .sys_clk(sys_clk), .rst(rst), .cfgLoad(cfgLoad), .detectorPrimarySelect(detectorPrimarySelect),
    .detectorSecondarySelect(detectorSecondarySelect), .loopDivideModulus(loopDivideModulus),
    .filterPathSelect(filterPathSelect), .crystalFineTuneEnable(crystalFineTuneEnable),
    .crystalDetectorDisable(crystalDetectorDisable), .oscillatorRangeSelect(oscillatorRangeSelect),
    .crystalRatioTableSelect(crystalRatioTableSelect), .pumpCurrentRange(pumpCurrentRange),
    .refPinTick(refPinTick), .externalLoopInputPin(externalLoopInputPin), .detectorRefTick(detectorRefTick),
    .detectorFbTick(detectorFbTick), .externalFilterOn(externalFilterOn), .fineTuneOn(fineTuneOn),
    .crystalDetectorOn(crystalDetectorOn), .lowSpeedRange(lowSpeedRange), .crystalOscOff(crystalOscOff),
    .pumpRangeOut(pumpRangeOut), .pump32uA(pump32uA), .clocksPerLine(clocksPerLine),
    .lineCountMatch(lineCountMatch)
);

// file: bench/pld_host_model.sv
module pld_host_model (
    input  logic        sys_clk,  // Clock
    output logic        cfgLoad,  // Write strobe
    output logic [46:0] cfgWord   // All settings, packed
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cfgLoad = 1'b0;
        cfgWord = '0;
    end
    // ****************************************************************
    // Writes every setting at once; the word holds until the next write.
    // ****************************************************************
    task automatic write_cfg(input logic [2:0] pd, input logic [11:0] refMod, input logic fbSrc,
                             input logic [14:0] fbMod, input logic [5:0] post, input logic [3:0] bits,
                             input logic [2:0] ratio, input logic [2:0] pumpKind);
        @(negedge sys_clk);
        cfgWord = {pumpKind, ratio, bits, post, fbMod, fbSrc, refMod, pd};
        cfgLoad = 1'b1;
        @(negedge sys_clk);
        cfgLoad = 1'b0;
    endtask
endmodule

// file: bench/pld_testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk, rst, crysT, pinT, extT, vcoT, cfgLoad;
    logic [46:0] cfgWord;
    logic        refT, fbT, outT, filtOn, tuneOn, detOn, lowSpd, oscOff, p32, kindOut, match;
    logic [1:0]  pumpOut;
    logic [15:0] perLine;
    int          fails = 0, compares = 0, refCnt = 0, fbCnt = 0, outCnt = 0;
    pld_host_model host_u (.sys_clk(sys_clk), .cfgLoad(cfgLoad), .cfgWord(cfgWord));
    pld_divider_path dut_u (
        .sys_clk(sys_clk), .rst(rst), .cfgLoad(cfgLoad), .refdivSourceSelect(cfgWord[0]),
        .detectorPrimarySelect(cfgWord[1]), .detectorSecondarySelect(cfgWord[2]),
        .inputDivideModulus(cfgWord[14:3]), .loopDividerSourceSelect(cfgWord[15]),
        .loopDivideModulus(cfgWord[30:16]), .outputStageOneModulus(cfgWord[32:31]),
        .outputStageTwoModulus(cfgWord[34:33]), .outputStageThreeModulus(cfgWord[36:35]),
        .filterPathSelect(cfgWord[37]), .crystalFineTuneEnable(cfgWord[38]),
        .crystalDetectorDisable(cfgWord[39]), .oscillatorRangeSelect(cfgWord[40]),
        .crystalRatioTableSelect(cfgWord[43:41]), .pumpCurrentRange(cfgWord[45:44]),
        .oscillatorKindBit(cfgWord[46]), .crystalTick(crysT), .refPinTick(pinT), .externalLoopInputPin(extT),
        .vcoTick(vcoT), .detectorRefTick(refT), .detectorFbTick(fbT), .outClkTick(outT),
        .externalFilterOn(filtOn), .fineTuneOn(tuneOn), .crystalDetectorOn(detOn), .lowSpeedRange(lowSpd),
        .crystalOscOff(oscOff), .pumpRangeOut(pumpOut), .pump32uA(p32), .oscillatorKindOut(kindOut),
        .clocksPerLine(perLine), .lineCountMatch(match)
    );
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (refT === 1'b1) refCnt <= refCnt + 1;
        if (fbT === 1'b1) fbCnt <= fbCnt + 1;
        if (outT === 1'b1) outCnt <= outCnt + 1;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // Ticks are {vco, loop pin, ref pin, crystal}; the ref pin fires once every pinPer cycles.
    task automatic run(input int n, input logic [3:0] tk, input int pinPer);
        refCnt = 0; fbCnt = 0; outCnt = 0;
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk);
            {vcoT, extT, crysT} = {tk[3:2], tk[0]};
            pinT = tk[1] && (i % pinPer == 0);
        end
        @(negedge sys_clk);
        {vcoT, extT, pinT, crysT} = 4'h0;
        repeat (8) @(negedge sys_clk);
    endtask
    task automatic t_modes();
        logic [3:0] b;
        for (int i = 0; i < 4; i++) begin
            b = i[0] ? 4'h5 : 4'hA;
            host_u.write_cfg(3'h0, 12'h001, 1'b1, 15'h0001, 6'h00, b, 3'h4 + i[2:0], {i[0], i[1:0]});
            repeat (2) @(negedge sys_clk);
            chk(filtOn, b[0]);
            chk(tuneOn, b[1]);
            chk(detOn, !b[2]);
            chk(lowSpd, b[3]);
            chk(oscOff, i == 3);
            chk(pumpOut, i[1:0]);
            chk(p32, i == 3);
            chk(kindOut, i[0]);
        end
    endtask
    task automatic t_standalone();
        host_u.write_cfg(3'h0, 12'h003, 1'b1, 15'h0005, 6'h09, 4'h0, 3'h0, 3'h0);
        run(60, 4'hF, 1);
        chk(refCnt, 20);
        chk(fbCnt, 12);
        chk(outCnt, 10);
        host_u.write_cfg(3'h0, 12'h003, 1'b0, 15'h0005, 6'h09, 4'h0, 3'h0, 3'h0);
        run(60, 4'hF, 1);
        chk(fbCnt, 2);
    endtask
    task automatic t_crystal_off();
        host_u.write_cfg(3'h0, 12'h001, 1'b1, 15'h0005, 6'h00, 4'h0, 3'h7, 3'h0);
        run(20, 4'h1, 1);
        chk(refCnt, 0);
        host_u.write_cfg(3'h0, 12'h001, 1'b1, 15'h0005, 6'h00, 4'h0, 3'h0, 3'h0);
        run(20, 4'h1, 1);
        chk(refCnt, 20);
    endtask
    task automatic t_line_lock();
        host_u.write_cfg(3'h2, 12'h003, 1'b0, 15'h0008, 6'h03, 4'hD, 3'h7, 3'h3);
        run(128, 4'hA, 32);
        chk(refCnt, 4);
        chk(fbCnt, 4);
        chk(perLine, 16'h0008);
        chk(match, 1'b1);
        host_u.write_cfg(3'h6, 12'h003, 1'b0, 15'h0008, 6'h03, 4'hD, 3'h7, 3'h3);
        run(40, 4'h6, 1);
        chk(refCnt, 40);
        chk(fbCnt, 40);
        // Selects 01: input divider on the pin against the external loop pin.
        host_u.write_cfg(3'h5, 12'h003, 1'b0, 15'h0008, 6'h03, 4'hD, 3'h7, 3'h3);
        run(30, 4'h6, 1);
        chk(refCnt, 10);
        chk(fbCnt, 30);
    endtask
    task automatic t_ref_max();
        host_u.write_cfg(3'h1, 12'h000, 1'b1, 15'h0005, 6'h00, 4'h0, 3'h0, 3'h0);
        run(4095, 4'h2, 1);
        chk(refCnt, 0);
        run(1, 4'h2, 1);
        chk(refCnt, 1);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        print_verdict();
    end
    initial begin
        {rst, crysT, pinT, extT, vcoT} = 5'h10;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        t_modes();
        t_standalone();
        t_crystal_off();
        t_line_lock();
        t_ref_max();
        print_verdict();
    end
endmodule
